// ===== include/lcis_pkg.sv
// lcis_pkg: constants and carrier types for the logic cell input-selection stage
// assumes an 8-bit register port with a small word address space

package lcis_pkg;

   // register port geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // selector geometry
   localparam int SEL_W = 5;
   localparam int NUM_CAND = 32;
   localparam int LINE_CNT = 3;

   // register word offsets
   localparam logic [ADDR_W-1:0] OFF_DATA1_SRC = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_DATA2_SRC = 4'h1;
   localparam logic [ADDR_W-1:0] OFF_DATA3_SRC = 4'h2;
   localparam logic [ADDR_W-1:0] OFF_LINE_STATE = 4'h3;

   // selector field position inside each source register
   localparam int CODE_LSB = 0;
   localparam int CODE_MSB = 4;

   // upper, unimplemented bits of a source register
   localparam int PAD_W = DATA_W - SEL_W;

   // value the selectors take at power-on or brown-out (any value is legal)
   localparam logic [SEL_W-1:0] SEL_POR_VAL = 5'h00;

   // reset value of read data, also returned when there is no read or an unmapped read
   localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;

   typedef logic [DATA_W-1:0] lcis_data_t;
   typedef logic [SEL_W-1:0] lcis_code_t;

   // one register request, sampled on the rising clock edge
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } lcis_req_s;

   // the routed data lines handed to the gating stage
   typedef struct packed {
      logic d3;
      logic d2;
      logic d1;
   } lcis_lines_s;

endpackage : lcis_pkg

// ===== logic/lcis_mux.sv
// lcis_mux: one combinational candidate selector
// assumes sel is an index into cand; out-of-range codes give zero

`timescale 1ns/1ps

module lcis_mux #(
   parameter int N_CAND = 32,
   parameter int SW = 5
) (
   // candidates and code
   input wire logic [N_CAND-1:0] cand,
   input wire logic [SW-1:0] sel,
   // routed signal
   output logic y
);

   wire logic in_range;

   assign in_range = (32'(sel) < N_CAND);
   assign y = in_range ? cand[sel] : 1'b0;

endmodule : lcis_mux

// ===== logic/lcis_top.sv
// lcis_top: input-selection stage of a configurable logic cell
// assumes all inputs synchronous to clk; candidates come from pins and peripherals
//
// Function
// - data1 source register bits 4:0 pick which of 32 candidates drives line 1
// - data2 source register bits 4:0 pick which candidate drives line 2
// - data3 source register bits 4:0 pick which candidate drives line 3
// - bits 7:5 of each source register ignore writes and read as zero
// - selectors are unknown after power-on or brown-out, kept over other resets
// - code n, binary 00000 to 11111, routes candidate n to its line
//
// Chosen here: the strobed register port and the register offsets.

`timescale 1ns/1ps

module lcis_top #(
   parameter int N_CAND = lcis_pkg::NUM_CAND
) (
   // clock and resets
   input wire logic clk,
   input wire logic srst,
   input wire logic por_rst,
   // register port
   input wire lcis_pkg::lcis_req_s req,
   output lcis_pkg::lcis_data_t rdata,
   // candidate signals, index n is selector code n
   input wire logic [N_CAND-1:0] cand_in,
   // selected data lines to the gating stage
   output lcis_pkg::lcis_lines_s lines
);

   import lcis_pkg::*;

   // selector registers
   lcis_code_t line1_source_code_ff;
   lcis_code_t line2_source_code_ff;
   lcis_code_t line3_source_code_ff;
   lcis_code_t nxt_line1_source_code;
   lcis_code_t nxt_line2_source_code;
   lcis_code_t nxt_line3_source_code;

   // read data and routed lines
   lcis_data_t rdata_ff;
   lcis_data_t nxt_rdata;
   lcis_lines_s lines_ff;
   lcis_lines_s nxt_lines;

   // address decode
   wire logic hit_d1;
   wire logic hit_d2;
   wire logic hit_d3;
   wire logic hit_st;
   wire logic wr_d1;
   wire logic wr_d2;
   wire logic wr_d3;

   // read selection
   wire lcis_data_t word_d1;
   wire lcis_data_t word_d2;
   wire lcis_data_t word_d3;
   wire lcis_data_t word_st;
   wire lcis_data_t rd_word;

   // mux outputs
   wire logic routed1;
   wire logic routed2;
   wire logic routed3;

   assign hit_d1 = (req.addr == OFF_DATA1_SRC);
   assign hit_d2 = (req.addr == OFF_DATA2_SRC);
   assign hit_d3 = (req.addr == OFF_DATA3_SRC);
   assign hit_st = (req.addr == OFF_LINE_STATE);

   assign wr_d1 = req.wr && hit_d1;
   assign wr_d2 = req.wr && hit_d2;
   assign wr_d3 = req.wr && hit_d3;

   // only the code field is stored; upper write bits fall away
   assign nxt_line1_source_code = wr_d1 ? req.wdata[CODE_MSB:CODE_LSB]
                                        : line1_source_code_ff;
   assign nxt_line2_source_code = wr_d2 ? req.wdata[CODE_MSB:CODE_LSB]
                                        : line2_source_code_ff;
   assign nxt_line3_source_code = wr_d3 ? req.wdata[CODE_MSB:CODE_LSB]
                                        : line3_source_code_ff;

   // srst is left out on purpose so codes survive ordinary resets
   always_ff @(posedge clk) begin
      if (por_rst) begin
         line1_source_code_ff <= SEL_POR_VAL;
         line2_source_code_ff <= SEL_POR_VAL;
         line3_source_code_ff <= SEL_POR_VAL;
      end else begin
         line1_source_code_ff <= nxt_line1_source_code;
         line2_source_code_ff <= nxt_line2_source_code;
         line3_source_code_ff <= nxt_line3_source_code;
      end
   end

   // readback words, unimplemented bits forced to zero
   assign word_d1 = {{PAD_W{1'b0}}, line1_source_code_ff};
   assign word_d2 = {{PAD_W{1'b0}}, line2_source_code_ff};
   assign word_d3 = {{PAD_W{1'b0}}, line3_source_code_ff};
   assign word_st = {{(DATA_W - LINE_CNT){1'b0}}, lines_ff};

   assign rd_word = hit_d1 ? word_d1
                  : hit_d2 ? word_d2
                  : hit_d3 ? word_d3
                  : hit_st ? word_st
                  : RDATA_RST;

   // read data stand for exactly the cycle after the strobe
   assign nxt_rdata = req.rd ? rd_word : RDATA_RST;

   always_ff @(posedge clk) begin
      if (srst || por_rst) begin
         rdata_ff <= RDATA_RST;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // the three selectors, purely combinational
   lcis_mux #(
      .N_CAND(N_CAND),
      .SW(SEL_W)
   ) u_mux1 (
      .cand(cand_in),
      .sel(line1_source_code_ff),
      .y(routed1)
   );

   lcis_mux #(
      .N_CAND(N_CAND),
      .SW(SEL_W)
   ) u_mux2 (
      .cand(cand_in),
      .sel(line2_source_code_ff),
      .y(routed2)
   );

   lcis_mux #(
      .N_CAND(N_CAND),
      .SW(SEL_W)
   ) u_mux3 (
      .cand(cand_in),
      .sel(line3_source_code_ff),
      .y(routed3)
   );

   assign nxt_lines = '{d3: routed3, d2: routed2, d1: routed1};

   // one output flop, no enable, so a recode shows on the next edge
   always_ff @(posedge clk) begin
      if (srst || por_rst) begin
         lines_ff <= '0;
      end else begin
         lines_ff <= nxt_lines;
      end
   end

   assign rdata = rdata_ff;
   assign lines = lines_ff;

   // write-data code one edge late, so the recode checks need no nested sampling
   lcis_code_t wdata_code_ff;

   always_ff @(posedge clk) begin
      wdata_code_ff <= req.wdata[CODE_MSB:CODE_LSB];
   end

   // checks

   property p_wr_d1;
      @(posedge clk) disable iff (por_rst)
      wr_d1 |=> line1_source_code_ff == $past(req.wdata[CODE_MSB:CODE_LSB]);
   endproperty
   a_wr_d1: assert property (p_wr_d1)
      else $error("data1 source code not taken from write");

   property p_wr_d2;
      @(posedge clk) disable iff (por_rst)
      wr_d2 |=> line2_source_code_ff == $past(req.wdata[CODE_MSB:CODE_LSB]);
   endproperty
   a_wr_d2: assert property (p_wr_d2)
      else $error("data2 source code not taken from write");

   property p_wr_d3;
      @(posedge clk) disable iff (por_rst)
      wr_d3 |=> line3_source_code_ff == $past(req.wdata[CODE_MSB:CODE_LSB]);
   endproperty
   a_wr_d3: assert property (p_wr_d3)
      else $error("data3 source code not taken from write");

   property p_src_upper_zero;
      @(posedge clk) disable iff (srst || por_rst)
      req.rd && (hit_d1 || hit_d2 || hit_d3) |=> rdata[DATA_W-1:SEL_W] == '0;
   endproperty
   a_src_upper_zero: assert property (p_src_upper_zero)
      else $error("unimplemented source bits read nonzero");

   property p_readback_d1;
      @(posedge clk) disable iff (srst || por_rst)
      wr_d1 ##1 (req.rd && hit_d1)
      |=> rdata == {{PAD_W{1'b0}}, $past(req.wdata[CODE_MSB:CODE_LSB], 2)};
   endproperty
   a_readback_d1: assert property (p_readback_d1)
      else $error("data1 source readback differs from last write");

   property p_readback_d2;
      @(posedge clk) disable iff (srst || por_rst)
      wr_d2 ##1 (req.rd && hit_d2)
      |=> rdata == {{PAD_W{1'b0}}, $past(req.wdata[CODE_MSB:CODE_LSB], 2)};
   endproperty
   a_readback_d2: assert property (p_readback_d2)
      else $error("data2 source readback differs from last write");

   property p_readback_d3;
      @(posedge clk) disable iff (srst || por_rst)
      wr_d3 ##1 (req.rd && hit_d3)
      |=> rdata == {{PAD_W{1'b0}}, $past(req.wdata[CODE_MSB:CODE_LSB], 2)};
   endproperty
   a_readback_d3: assert property (p_readback_d3)
      else $error("data3 source readback differs from last write");

   property p_keep_over_srst;
      @(posedge clk) disable iff (por_rst)
      srst && !req.wr |=> $stable(line1_source_code_ff) && $stable(line2_source_code_ff)
                          && $stable(line3_source_code_ff);
   endproperty
   a_keep_over_srst: assert property (p_keep_over_srst)
      else $error("source code changed across ordinary reset");

   // only edges that load the lines from the muxes are judged, not reset edges
   property p_route;
      @(posedge clk) disable iff (por_rst)
      !srst && !por_rst |=> lines_ff.d1 == $past(cand_in[line1_source_code_ff])
          && lines_ff.d2 == $past(cand_in[line2_source_code_ff])
          && lines_ff.d3 == $past(cand_in[line3_source_code_ff]);
   endproperty
   a_route: assert property (p_route)
      else $error("data line does not follow its selected candidate");

   property p_recode;
      @(posedge clk) disable iff (srst || por_rst)
      wr_d2 ##1 !srst |=> lines_ff.d2 == $past(cand_in[wdata_code_ff]);
   endproperty
   a_recode: assert property (p_recode)
      else $error("line 2 not rerouted two edges after a write");

   property p_recode_d1;
      @(posedge clk) disable iff (srst || por_rst)
      wr_d1 ##1 !srst |=> lines_ff.d1 == $past(cand_in[wdata_code_ff]);
   endproperty
   a_recode_d1: assert property (p_recode_d1)
      else $error("line 1 not rerouted two edges after a write");

   property p_recode_d3;
      @(posedge clk) disable iff (srst || por_rst)
      wr_d3 ##1 !srst |=> lines_ff.d3 == $past(cand_in[wdata_code_ff]);
   endproperty
   a_recode_d3: assert property (p_recode_d3)
      else $error("line 3 not rerouted two edges after a write");

   property p_rdata_only_after_rd;
      @(posedge clk) disable iff (srst || por_rst)
      !req.rd |=> rdata == RDATA_RST;
   endproperty
   a_rdata_only_after_rd: assert property (p_rdata_only_after_rd)
      else $error("read data present without a read");

   // outside power-on reset, a code moves only on a write to its own address
   property p_hold_d1;
      @(posedge clk) disable iff (por_rst)
      !wr_d1 |=> $stable(line1_source_code_ff);
   endproperty
   a_hold_d1: assert property (p_hold_d1)
      else $error("data1 source code changed without a write to it");

   property p_hold_d2;
      @(posedge clk) disable iff (por_rst)
      !wr_d2 |=> $stable(line2_source_code_ff);
   endproperty
   a_hold_d2: assert property (p_hold_d2)
      else $error("data2 source code changed without a write to it");

   property p_hold_d3;
      @(posedge clk) disable iff (por_rst)
      !wr_d3 |=> $stable(line3_source_code_ff);
   endproperty
   a_hold_d3: assert property (p_hold_d3)
      else $error("data3 source code changed without a write to it");

   property p_status_read;
      @(posedge clk) disable iff (srst || por_rst)
      req.rd && hit_st |=> rdata == {{(DATA_W - LINE_CNT){1'b0}}, $past(lines_ff)};
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("line state readback differs from the data lines");

   property p_unmapped_read;
      @(posedge clk) disable iff (srst || por_rst)
      req.rd && !(hit_d1 || hit_d2 || hit_d3 || hit_st) |=> rdata == RDATA_RST;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped address read nonzero");

   property p_lines_srst;
      @(posedge clk) disable iff (por_rst)
      srst |=> lines_ff == '0;
   endproperty
   a_lines_srst: assert property (p_lines_srst)
      else $error("data lines not cleared by ordinary reset");

   c_wr_d1: cover property (@(posedge clk) disable iff (por_rst) wr_d1 ##1 req.rd && hit_d1);
   c_wr_d3: cover property (@(posedge clk) disable iff (por_rst) wr_d3 ##2 lines_ff.d3);
   c_srst: cover property (@(posedge clk) disable iff (por_rst) srst ##1 !srst ##1 lines_ff.d1);
   c_status: cover property (@(posedge clk) disable iff (por_rst)
      req.rd && hit_st ##1 rdata != '0);
   c_recode: cover property (@(posedge clk) disable iff (por_rst) wr_d2 ##2 lines_ff.d2);

endmodule : lcis_top

// ===== verif/tb.sv
// tb: self-checking bench for the logic cell input-selection stage
// assumes lcis_pkg is compiled first; the bench drives every input port of lcis_top

`timescale 1ns/1ps

module tb;
   import lcis_pkg::*;
   logic clk;
   logic srst;
   logic por_rst;
   lcis_req_s req;
   lcis_data_t rdata;
   logic [NUM_CAND-1:0] cand_in;
   lcis_lines_s lines;
   int n_errors;
   int samples_checked;

   lcis_top uut (.clk(clk), .srst(srst), .por_rst(por_rst), .req(req),
      .rdata(rdata), .cand_in(cand_in), .lines(lines));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic conclude();
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   // bus tasks start just after an edge; reg_wr returns just after the sampling edge, reg_rd one edge later
   task automatic reg_wr(input logic [ADDR_W-1:0] a, input lcis_data_t d);
      req.wr <= 1'b1;
      req.rd <= 1'b0;
      req.addr <= a;
      req.wdata <= d;
      @(posedge clk);
   endtask : reg_wr

   task automatic reg_rd(input logic [ADDR_W-1:0] a, output lcis_data_t v);
      req.rd <= 1'b1;
      req.wr <= 1'b0;
      req.addr <= a;
      @(posedge clk);
      req.rd <= 1'b0;
      @(negedge clk);
      v = rdata;
      @(posedge clk);
   endtask : reg_rd

   // each write read back at once with upper bits set, then read-only and unmapped writes
   task automatic t_regs();
      lcis_data_t v;
      reg_wr(OFF_DATA1_SRC, 8'hE5);
      reg_rd(OFF_DATA1_SRC, v);
      check(v, 8'h05);
      reg_wr(OFF_DATA2_SRC, 8'h3A);
      reg_rd(OFF_DATA2_SRC, v);
      check(v, 8'h1A);
      reg_wr(OFF_DATA3_SRC, 8'hFF);
      reg_rd(OFF_DATA3_SRC, v);
      check(v, 8'h1F);
      reg_wr(OFF_LINE_STATE, 8'hFF);
      reg_wr(4'hF, 8'h11);
      reg_rd(4'hF, v);
      check(v, 8'h00);
      reg_rd(OFF_DATA2_SRC, v);
      check(v, 8'h1A);
   endtask : t_regs

   // every code on every line, new code and new candidates seen one edge later
   task automatic t_route();
      logic [31:0] pat [3];
      lcis_code_t c1;
      lcis_code_t c2;
      lcis_code_t c3;
      for (int n = 0; n < NUM_CAND; n++) begin
         c1 = n[4:0];
         c2 = c1 + 5'h01;
         c3 = 5'h1F - c1;
         pat[0] = 32'h1 << n;
         pat[1] = ~(32'h1 << n);
         pat[2] = 32'hA5C3_0F96 ^ (32'h1 << n);
         reg_wr(OFF_DATA1_SRC, {3'b111, c1});
         reg_wr(OFF_DATA2_SRC, {3'b101, c2});
         reg_wr(OFF_DATA3_SRC, {3'b010, c3});
         for (int k = 0; k < 3; k++) begin
            req <= '0;
            cand_in <= pat[k];
            @(posedge clk);
            @(negedge clk);
            check(lines, {pat[k][c3], pat[k][c2], pat[k][c1]});
            @(posedge clk);
         end
      end
   endtask : t_route

   // ordinary reset clears the lines but keeps every selector code
   task automatic t_srst();
      lcis_data_t v;
      reg_wr(OFF_DATA1_SRC, 8'h07);
      reg_wr(OFF_DATA2_SRC, 8'h09);
      reg_wr(OFF_DATA3_SRC, 8'h0B);
      req <= '0;
      cand_in <= 32'h0000_0A80;
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check(lines, 3'b000);
      @(posedge clk);
      srst <= 1'b0;
      reg_rd(OFF_DATA1_SRC, v);
      check(v, 8'h07);
      reg_rd(OFF_DATA2_SRC, v);
      check(v, 8'h09);
      reg_rd(OFF_DATA3_SRC, v);
      check(v, 8'h0B);
      reg_rd(OFF_LINE_STATE, v);
      check(v, 8'h07);
      @(negedge clk);
      check(lines, 3'b111);
   endtask : t_srst

   initial begin
      n_errors = 0;
      samples_checked = 0;
      srst = 1'b1;
      por_rst = 1'b1;
      req = '0;
      cand_in = '0;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      por_rst <= 1'b0;
      t_regs();
      t_route();
      t_srst();
      conclude();
   end

   // hang guard, far beyond the length of the run
   initial begin
      #100000;
      n_errors++;
      conclude();
   end
endmodule : tb
